// >>> inc/sirc_pkg.sv
// Shared constants and types for the serial-infrared pulse codec
package sirc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_ADDR       = 8'h00;
	localparam logic [7:0]  STAT_ADDR       = 8'h04;
	localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
	localparam int          CTRL_CLK_SEL    = 0;
	localparam int          CTRL_FIXED      = 1;
	localparam int          CTRL_SLEEP      = 2;
	localparam int          CTRL_DIV_LSB    = 3;
	localparam int          STAT_OSC_RUN    = 0;
	localparam int          STAT_ENC_BUSY   = 1;
	localparam int          STAT_DEC_BUSY   = 2;
	localparam int          STAT_OVERRUN    = 3;
	localparam int          STAT_LEVEL_LSB  = 4;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam logic [3:0]  BIT_TICKS_M1    = 4'hF;
	localparam logic [3:0]  PULSE_TICKS     = 4'h3;
	localparam logic [2:0]  MONO_XTAL_CYC   = 3'h6;
	localparam int          FIFO_DEPTH      = 16;
	localparam int          FIFO_WIDTH      = 1;

	// ------------------------------------------------------------
	// Synchroniser bit order and reset values
	// ------------------------------------------------------------
	localparam int          SY_TX           = 0;
	localparam int          SY_ORX          = 1;
	localparam int          SY_X16          = 2;
	localparam int          SY_XTAL         = 3;
	localparam int          SY_CLR          = 4;
	localparam logic [4:0]  SYNC_RST        = 5'h01;

	typedef enum logic [1:0] {
		SIRC_ENC_IDLE,
		SIRC_ENC_BIT,
		SIRC_ENC_MONO
	} sirc_enc_e;

	// Crystal cycles per x16 tick, from the divider select
	function automatic logic [4:0] sirc_div_ratio(input logic [2:0] sel);
		unique case (sel)
			3'h0: sirc_div_ratio = 5'h02;
			3'h1: sirc_div_ratio = 5'h04;
			3'h2: sirc_div_ratio = 5'h06;
			3'h3: sirc_div_ratio = 5'h0C;
			3'h4: sirc_div_ratio = 5'h18;
			3'h5: sirc_div_ratio = 5'h01;
			3'h6: sirc_div_ratio = 5'h08;
			3'h7: sirc_div_ratio = 5'h10;
		endcase
	endfunction : sirc_div_ratio

endpackage : sirc_pkg

// >>> hdl/sirc_sync3.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module sirc_sync3 #(
	parameter int         W       = 5,
	parameter logic [4:0] RST_VAL = 5'h00
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Asynchronous levels in
	input  wire logic [W-1:0] async_i,
	// Filtered level and edges out
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] prev_r;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_r <= RST_VAL[W-1:0];
			s2_r <= RST_VAL[W-1:0];
			s3_r <= RST_VAL[W-1:0];
		end
		else
		begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			level_o <= RST_VAL[W-1:0];
			prev_r  <= RST_VAL[W-1:0];
		end
		else
		begin
			level_o <= (s2_r & s3_r) | (level_o & (s2_r ^ s3_r));
			prev_r  <= level_o;
		end
	end

	assign rise_o = level_o & ~prev_r;
	assign fall_o = ~level_o & prev_r;

endmodule : sirc_sync3

// >>> hdl/sirc_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module sirc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               clr_i,
	// Fill side
	input  wire logic               in_valid_i,
	output logic                    in_ready_o,
	input  wire logic [WIDTH-1:0]   in_data_i,
	// Drain side
	output logic                    out_valid_o,
	input  wire logic               out_ready_i,
	output logic      [WIDTH-1:0]   out_data_o,
	// Fill level
	output logic [$clog2(DEPTH):0]  level_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = (level_o != DEPTH[AW:0]);
	assign out_valid_o = (level_o != '0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_r[rptr_r];

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_r[wptr_r] <= in_data_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			level_o <= '0;
		end
		else if (clr_i)
		begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			level_o <= '0;
		end
		else
		begin
			if (push)
				wptr_r <= wptr_r + 1'b1;
			if (pop)
				rptr_r <= rptr_r + 1'b1;
			if (push && !pop)
				level_o <= level_o + 1'b1;
			else if (pop && !push)
				level_o <= level_o - 1'b1;
		end
	end

endmodule : sirc_fifo

// >>> hdl/sirc_codec.sv
// Serial-infrared pulse encoder and decoder with an AHB-Lite control slave
// Contract
// - Clear input resets encoder and decoder machines
// - Accept short or 3/16 pulses, demodulate them
// - Optical output carries modulated UART serial data
// - Fixed-pulse select high selects monoshot transmit
// - Monoshot: falling edge gives six-crystal-cycle pulse
// - Fixed-pulse select defaults low
// - Sleep stops only the oscillator
// - External clock select also stops oscillator
// - External clock rising edge is one tick
// - Act on falling edges of UART serial input
// - Clock select high external, low crystal
// - Three divider selects set the baud rate
`timescale 1ns/10ps
module sirc_codec (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// UART side
	input  wire logic        uart_tx_i,
	output logic             uart_rx_o,
	// Transceiver side
	input  wire logic        optical_rx_in_i,
	output logic             optical_tx_out_o,
	// Clocks, clear and oscillator control
	input  wire logic        baud_x16_clock_i,
	input  wire logic        crystal_clk_i,
	input  wire logic        codec_clear_n_i,
	output logic             osc_enable_o
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [4:0] sy_lvl;
	logic [4:0] sy_rise;
	logic [4:0] sy_fall;

	sirc_sync3 #(
		.W       (5),
		.RST_VAL (sirc_pkg::SYNC_RST)
	) u_sync (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.async_i ({codec_clear_n_i, crystal_clk_i, baud_x16_clock_i, optical_rx_in_i, uart_tx_i}),
		.level_o (sy_lvl),
		.rise_o  (sy_rise),
		.fall_o  ()
	);

	logic clr_n;
	logic tx_fall;
	logic sy_fall_tx;
	assign clr_n   = sy_lvl[sirc_pkg::SY_CLR];
	assign tx_fall = sy_fall_tx;

	// Falling edge of the serial input only; other falls unused
	logic tx_prev_r;
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			tx_prev_r <= 1'b1;
		else
			tx_prev_r <= sy_lvl[sirc_pkg::SY_TX];
	end
	assign sy_fall_tx = tx_prev_r & ~sy_lvl[sirc_pkg::SY_TX];

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic        overrun_r;
	logic        clk_sel;
	logic        fixed_pulse_select;
	logic        osc_sleep;
	logic [2:0]  divider_select;

	assign clk_sel            = ctrl_r[sirc_pkg::CTRL_CLK_SEL];
	assign fixed_pulse_select = ctrl_r[sirc_pkg::CTRL_FIXED];
	assign osc_sleep          = ctrl_r[sirc_pkg::CTRL_SLEEP];
	assign divider_select     = ctrl_r[sirc_pkg::CTRL_DIV_LSB +: 3];

	// ------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ------------------------------------------------------------
	logic       ap_take;
	logic       wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] stat_word;

	assign ap_take     = hsel_i & htrans_i[1] & hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (hready_i)
		begin
			wr_pend_r <= ap_take & hwrite_i;
			wr_addr_r <= haddr_i[7:0];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			hrdata_o <= 32'h0000_0000;
		else if (ap_take && !hwrite_i)
		begin
			unique case (haddr_i[7:0])
				sirc_pkg::CTRL_ADDR: hrdata_o <= ctrl_r;
				sirc_pkg::STAT_ADDR: hrdata_o <= stat_word;
				default:             hrdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Fixed-pulse select resets low
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= sirc_pkg::CTRL_RST;
		else if (wr_pend_r && wr_addr_r == sirc_pkg::CTRL_ADDR)
			ctrl_r <= {26'h0, hwdata_i[5:0]};
	end

	// ------------------------------------------------------------
	// Oscillator and tick generation
	// ------------------------------------------------------------
	// Registered so the analog cell never sees a glitch
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			osc_enable_o <= 1'b1;
		else
			osc_enable_o <= ~osc_sleep & ~clk_sel;
	end

	logic       xtal_tick;
	logic       div_tick;
	logic       tick16;
	logic [4:0] div_cnt_r;

	assign xtal_tick = sy_rise[sirc_pkg::SY_XTAL] & osc_enable_o;

	// Crystal divider
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt_r <= 5'h00;
		else if (tx_fall)
			div_cnt_r <= 5'h00; // Realign ticks to the bit start: full three-tick pulse
		else if (xtal_tick)
		begin
			if (div_cnt_r >= sirc_pkg::sirc_div_ratio(divider_select) - 5'h01)
				div_cnt_r <= 5'h00;
			else
				div_cnt_r <= div_cnt_r + 5'h01;
		end
	end
	assign div_tick = xtal_tick && (div_cnt_r >= sirc_pkg::sirc_div_ratio(divider_select) - 5'h01);

	// Source select; external clock counts on its rising edge
	assign tick16 = clk_sel ? sy_rise[sirc_pkg::SY_X16] : div_tick;

	// ------------------------------------------------------------
	// Encoder
	// ------------------------------------------------------------
	sirc_pkg::sirc_enc_e enc_state_r;
	logic [3:0]          enc_cnt_r;
	logic [2:0]          mono_cnt_r;
	logic                bit_zero_r;
	logic                high_316;
	logic                high_mono;

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enc_state_r <= sirc_pkg::SIRC_ENC_IDLE;
			enc_cnt_r   <= 4'h0;
			mono_cnt_r  <= 3'h0;
			bit_zero_r  <= 1'b0;
		end
		else if (!clr_n)
		begin
			enc_state_r <= sirc_pkg::SIRC_ENC_IDLE;
			enc_cnt_r   <= 4'h0;
			mono_cnt_r  <= 3'h0;
			bit_zero_r  <= 1'b0;
		end
		else
		begin
			unique case (enc_state_r)
				sirc_pkg::SIRC_ENC_IDLE:
				begin
					if (tx_fall)
					begin
						enc_state_r <= fixed_pulse_select ? sirc_pkg::SIRC_ENC_MONO
						                                  : sirc_pkg::SIRC_ENC_BIT;
						enc_cnt_r   <= 4'h0;
						mono_cnt_r  <= 3'h0;
						bit_zero_r  <= 1'b1;
					end
				end
				sirc_pkg::SIRC_ENC_BIT:
				begin
					if (tx_fall)
					begin
						enc_cnt_r  <= 4'h0;
						bit_zero_r <= 1'b1;
					end
					else if (tick16 && enc_cnt_r == sirc_pkg::BIT_TICKS_M1)
					begin
						// Next bit sampled at the boundary; a one ends the burst
						enc_cnt_r  <= 4'h0;
						bit_zero_r <= ~sy_lvl[sirc_pkg::SY_TX];
						if (sy_lvl[sirc_pkg::SY_TX])
							enc_state_r <= sirc_pkg::SIRC_ENC_IDLE;
					end
					else if (tick16)
						enc_cnt_r <= enc_cnt_r + 4'h1;
				end
				sirc_pkg::SIRC_ENC_MONO:
				begin
					// Pulse starts on the next crystal edge, lasts six
					if (xtal_tick)
					begin
						if (mono_cnt_r == sirc_pkg::MONO_XTAL_CYC)
							enc_state_r <= sirc_pkg::SIRC_ENC_IDLE;
						else
							mono_cnt_r <= mono_cnt_r + 3'h1;
					end
				end
			endcase
		end
	end

	assign high_316  = enc_state_r == sirc_pkg::SIRC_ENC_BIT && bit_zero_r && enc_cnt_r < sirc_pkg::PULSE_TICKS;
	assign high_mono = enc_state_r == sirc_pkg::SIRC_ENC_MONO && mono_cnt_r != 3'h0;

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			optical_tx_out_o <= 1'b0;
		else
			optical_tx_out_o <= high_316 | high_mono;
	end

	// ------------------------------------------------------------
	// Decoder: pulse tokens through the FIFO
	// ------------------------------------------------------------
	logic       push_valid;
	logic       push_ready;
	logic       pop_valid;
	logic       pop_ready;
	logic       pop_data;
	logic [4:0] fifo_level;
	logic       dec_active_r;
	logic       dec_bit_r;
	logic [3:0] dec_cnt_r;

	// Any rising edge counts once held two core cycles; shorter pulses are filtered out
	assign push_valid = sy_rise[sirc_pkg::SY_ORX] & clr_n;

	sirc_fifo #(
		.WIDTH (sirc_pkg::FIFO_WIDTH),
		.DEPTH (sirc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (core_clk_i),
		.rst_n_i     (rst_n),
		.clr_i       (~clr_n),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (1'b0),
		.out_valid_o (pop_valid),
		.out_ready_i (pop_ready),
		.out_data_o  (pop_data),
		.level_o     (fifo_level)
	);

	// Drain stalls for a whole bit while the line is held low
	assign pop_ready = clr_n & (!dec_active_r | (tick16 && dec_cnt_r == sirc_pkg::BIT_TICKS_M1));

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dec_active_r <= 1'b0;
			dec_cnt_r    <= 4'h0;
			dec_bit_r    <= 1'b1;
		end
		else if (!clr_n)
		begin
			dec_active_r <= 1'b0;
			dec_cnt_r    <= 4'h0;
			dec_bit_r    <= 1'b1;
		end
		else if (pop_ready && pop_valid)
		begin
			dec_active_r <= 1'b1;
			dec_cnt_r    <= 4'h0;
			dec_bit_r    <= pop_data;
		end
		else if (dec_active_r && tick16)
		begin
			if (dec_cnt_r == sirc_pkg::BIT_TICKS_M1)
				dec_active_r <= 1'b0;
			dec_cnt_r <= dec_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			uart_rx_o <= 1'b1;
		else
			uart_rx_o <= dec_active_r ? dec_bit_r : 1'b1;
	end

	// Lost token is sticky; a new loss wins over the clear
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			overrun_r <= 1'b0;
		else if (push_valid && !push_ready)
			overrun_r <= 1'b1;
		else if (wr_pend_r && wr_addr_r == sirc_pkg::STAT_ADDR && hwdata_i[sirc_pkg::STAT_OVERRUN])
			overrun_r <= 1'b0;
	end

	assign stat_word = {23'h0, fifo_level, overrun_r, dec_active_r,
	                    enc_state_r != sirc_pkg::SIRC_ENC_IDLE, osc_enable_o};

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	logic [3:0] mono_seen_r;
	logic [3:0] p316_seen_r;
	logic [4:0] rx_seen_r;

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mono_seen_r <= 4'h0;
			p316_seen_r <= 4'h0;
			rx_seen_r   <= 5'h00;
		end
		else
		begin
			mono_seen_r <= !high_mono ? 4'h0 : mono_seen_r + {3'h0, xtal_tick};
			p316_seen_r <= (!high_316 || tx_fall) ? 4'h0 : p316_seen_r + {3'h0, tick16};
			rx_seen_r   <= (pop_ready && pop_valid) ? 5'h00 : rx_seen_r + {4'h0, dec_active_r & tick16};
		end
	end

	sequence clear_seen_s;
		!clr_n;
	endsequence
	sequence idle_after_s;
		enc_state_r == sirc_pkg::SIRC_ENC_IDLE && !dec_active_r ##1 !optical_tx_out_o && uart_rx_o;
	endsequence

	clear_machines_a: assert property (clear_seen_s |=> idle_after_s)
		else $error("clear did not idle the machines");
	mono_width_a: assert property ($fell(high_mono) && clr_n |-> mono_seen_r == 4'h6)
		else $error("monoshot pulse not six crystal cycles");
	mono_mode_a: assert property (tx_fall && clr_n && enc_state_r == sirc_pkg::SIRC_ENC_IDLE
		&& fixed_pulse_select |=> enc_state_r == sirc_pkg::SIRC_ENC_MONO)
		else $error("fixed select did not pick monoshot");
	pulse_316_a: assert property ($fell(high_316) && clr_n && !tx_fall |-> p316_seen_r == 4'h3)
		else $error("3/16 pulse not three ticks");
	tx_follows_a: assert property (high_316 || high_mono |=> optical_tx_out_o)
		else $error("optical output missed a pulse");
	osc_stop_a: assert property (clk_sel || osc_sleep |=> !osc_enable_o)
		else $error("oscillator left running");
	ext_tick_a: assert property (clk_sel |-> tick16 == sy_rise[sirc_pkg::SY_X16])
		else $error("external tick not used");
	pulse_taken_a: assert property (push_valid && push_ready |=> fifo_level != 5'h00)
		else $error("optical pulse not queued");
	rx_bit_a: assert property ($fell(dec_active_r) && clr_n |-> rx_seen_r == 5'h10 ##1 uart_rx_o)
		else $error("receive low not one bit");

endmodule : sirc_codec

// >>> tb/sirc_far_model.sv
// Far-side model: crystal, UART baud clock and pulse measurement
`timescale 1ns/10ps
module sirc_far_model (
	// Core clock
	input  wire logic core_clk_i,
	// Device outputs
	input  wire logic osc_enable_i,
	input  wire logic optical_tx_out_i,
	input  wire logic uart_rx_i,
	// Clocks to device
	output logic      crystal_clk_o,
	output logic      baud_x16_clock_o
);
	int tx_w = 0;
	int tx_n = 0;
	int rx_w = 0;
	int rx_n = 0;
	int tx_run = 0;
	int rx_run = 0;

	// Crystal stands still while disabled
	initial
	begin
		crystal_clk_o = 1'b0;
		#1;
		forever
		begin
			#16;
			crystal_clk_o = (osc_enable_i === 1'b1) ? ~crystal_clk_o : 1'b0;
		end
	end

	// Baud clock runs free; offset keeps it off core edges
	initial
	begin
		baud_x16_clock_o = 1'b0;
		#3;
		forever #20 baud_x16_clock_o = ~baud_x16_clock_o;
	end

	// Widths in core cycles
	always @(posedge core_clk_i)
	begin
		if (optical_tx_out_i === 1'b1)
			tx_run++;
		else if (tx_run > 0)
		begin
			tx_w = tx_run;
			tx_n++;
			tx_run = 0;
		end
		if (uart_rx_i === 1'b0)
			rx_run++;
		else if (rx_run > 0)
		begin
			rx_w = rx_run;
			rx_n++;
			rx_run = 0;
		end
	end
endmodule : sirc_far_model

// >>> tb/sirc_codec_tb.sv
// Self-checking bench for the pulse codec
`timescale 1ns/10ps
module sirc_codec_tb;
	localparam logic [31:0] CA = {24'h00_0000, sirc_pkg::CTRL_ADDR};
	localparam logic [31:0] SA = {24'h00_0000, sirc_pkg::STAT_ADDR};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        utx = 1'b1;
	logic        urx;
	logic        orx = 1'b0;
	logic        otx;
	logic        x16;
	logic        xtal;
	logic        clr_n = 1'b1;
	logic        osc_en;
	int          failures = 0;
	int          checks = 0;
	int          r[8] = '{2, 4, 6, 12, 24, 1, 8, 16};

	sirc_codec sirc_codec_i (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .uart_tx_i(utx), .uart_rx_o(urx),
		.optical_rx_in_i(orx), .optical_tx_out_o(otx), .baud_x16_clock_i(x16),
		.crystal_clk_i(xtal), .codec_clear_n_i(clr_n), .osc_enable_o(osc_en));
	sirc_far_model far (.core_clk_i(clk), .osc_enable_i(osc_en), .optical_tx_out_i(otx),
		.uart_rx_i(urx), .crystal_clk_o(xtal), .baud_x16_clock_o(x16));

	initial
	begin
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task finish_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task timeout;
		failures++;
		finish_test;
	endtask : timeout

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	function automatic logic near(input int w, input int e, input int t);
		near = (w >= e - t) && (w <= e + t);
	endfunction : near

	// Master waits on hready, never on a fixed count
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
		if (n >= 20) timeout;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
		if (n >= 20) timeout;
		rd = hrdata;
	endtask : ahb

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0000_0000, x);
		chk(x, e);
	endtask : rdc

	task wait_n(input logic rx, input int n0, input int lim);
		int k;
		k = 0;
		while ((rx ? far.rx_n : far.tx_n) == n0 && k < lim)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= lim) timeout;
	endtask : wait_n

	task pulse(input int w);
		@(posedge clk);
		orx <= 1'b1;
		cyc(w);
		orx <= 1'b0;
		cyc(w);
	endtask : pulse

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Line goes back high mid-bit so only the zero bits count
	task enc(input logic [31:0] c, input int bitc, input int pw, input int tol, input int nz);
		int n0;
		wr(CA, c);
		n0 = far.tx_n;
		@(posedge clk);
		utx <= 1'b0;
		cyc(bitc * nz - bitc / 2);
		utx <= 1'b1;
		wait_n(1'b0, n0, bitc * nz + 200);
		cyc(bitc * 2);
		chk({31'h0, near(far.tx_w, pw, tol)}, 32'h1);
		chk(far.tx_n - n0, nz);
	endtask : enc

	task t_regs;
		rdc(CA, sirc_pkg::CTRL_RST);
		wr(CA, 32'hFFFF_FFFE);
		rdc(CA, 32'h0000_003E);
		chk(hresp, 32'h0);
		rdc(32'h0000_0008, 32'h0000_0000);
		wr(CA, 32'h0000_0000);
		rdc(SA, 32'h0000_0001);
	endtask : t_regs

	task t_osc;
		wr(CA, 32'h1 << sirc_pkg::CTRL_SLEEP);
		cyc(3);
		chk(osc_en, 1'b0);
		rdc(CA, 32'h1 << sirc_pkg::CTRL_SLEEP);
		wr(CA, 32'h1 << sirc_pkg::CTRL_CLK_SEL);
		cyc(3);
		chk(osc_en, 1'b0);
		wr(CA, 32'h0000_0000);
		cyc(3);
		chk(osc_en, 1'b1);
	endtask : t_osc

	task t_dec;
		int n0;
		logic [31:0] x;
		wr(CA, 32'h5 << sirc_pkg::CTRL_DIV_LSB);
		n0 = far.rx_n;
		pulse(24);
		pulse(5);
		wait_n(1'b1, n0, 1000);
		chk({31'h0, near(far.rx_w, 256, 8)}, 32'h1);
		repeat (20) pulse(4);
		ahb(1'b0, SA, 32'h0000_0000, x);
		chk(x[sirc_pkg::STAT_OVERRUN], 1'b1);
		chk(x[8:4], 5'h10);
		wr(SA, 32'h1 << sirc_pkg::STAT_OVERRUN);
		cyc(2400);
		rdc(SA, 32'h0000_0001);
		pulse(4);
		cyc(30);
		clr_n <= 1'b0;
		cyc(10);
		chk(urx, 1'b1);
		clr_n <= 1'b1;
		cyc(10);
		rdc(SA, 32'h0000_0001);
	endtask : t_dec

	initial
	begin
		cyc(2);
		rst_n <= 1'b1;
		cyc(8);
		t_regs;
		t_osc;
		for (int s = 0; s < 8; s++)
			enc(32'(s) << sirc_pkg::CTRL_DIV_LSB, 128 * r[s], 24 * r[s], 8, 1);
		enc(32'h0000_0028, 128, 24, 8, 2);
		enc(32'h0000_0029, 160, 30, 10, 1);
		enc(32'h0000_002A, 128, 48, 2, 1);
		t_dec;
		finish_test;
	end
endmodule : sirc_codec_tb
